/* File: src/serial_register_port.v */
// Purpose: three-wire serial control port with configuration registers
// Assumes: mclk 125 MHz, serial clock at most 15.6 MHz (mclk/8), sampled as data
// Notes: serial clock edges are found by oversampling after two flops
`timescale 1ns/1ps
`include "serial_port_map.vh"

module serial_register_port
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // strap
  input wire mode_pin,
  // serial port pins
  input wire sclk,
  input wire port_select_n,
  input wire serial_io_in,
  output reg serial_io_out,
  output reg serial_io_oe,
  // configuration outputs
  output reg full_duplex_mode,
  output reg power_save_en,
  output reg bit_order_select,
  output reg [`DATA_W-1:0] rx_filter_cfg,
  output reg [`DATA_W-1:0] interp_cfg,
  output reg [`DATA_W-1:0] pll_mult_cfg,
  output reg [`DATA_W-1:0] amp_gain_cfg,
  // status
  output reg soft_reset_pulse,
  output reg busy
);

  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_INSTR = 2'b00;
  localparam [1:0] ST_WDATA = 2'b01;
  localparam [1:0] ST_RDATA = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  // ****************************************
  // declarations
  // ****************************************
  wire [`SYNC_W-1:0] pins_s;
  wire sclk_s;
  wire sel_n_s;
  wire sdi_s;
  wire mode_s;
  reg sclk_d_reg;
  wire sclk_rise;
  wire sclk_fall;
  reg [1:0] state_reg;
  reg [`BIT_CNT_W-1:0] bit_cnt_reg;
  reg [`DATA_W-1:0] shift_reg;
  reg [`DATA_W-1:0] shift_next;
  reg [`ADDR_W-1:0] addr_reg;
  reg [1:0] left_reg;
  reg wr_en_reg;
  reg [`ADDR_W-1:0] wr_addr_reg;
  reg [`DATA_W-1:0] wr_data_reg;
  wire mode_full;
  wire lsb_first;
  wire [`DATA_W-1:0] rd_data;
  wire [`DATA_W-1:0] ctrl0;
  wire [`DATA_W-1:0] iface;
  wire [`DATA_W-1:0] rxfilt;
  wire [`DATA_W-1:0] interp;
  wire [`DATA_W-1:0] pllmul;
  wire [`DATA_W-1:0] ampgain;

  // ****************************************
  // helpers
  // ****************************************
  function [`DATA_W-1:0] shift_in;
    input [`DATA_W-1:0] sh;
    input b;
    input lsb;
    begin
      if (lsb)
        shift_in = {b, sh[`DATA_W-1:1]};
      else
        shift_in = {sh[`DATA_W-2:0], b};
    end
  endfunction

  function [`ADDR_W-1:0] next_addr;
    input [`ADDR_W-1:0] a;
    input lsb;
    begin
      if (lsb)
        next_addr = a + `ADDR_STEP;
      else
        next_addr = a - `ADDR_STEP;
    end
  endfunction

  function pick_bit;
    input [`DATA_W-1:0] d;
    input [`BIT_CNT_W-1:0] idx;
    input lsb;
    begin
      if (lsb)
        pick_bit = d[idx];
      else
        pick_bit = d[`BIT_MAX - idx];
    end
  endfunction

  // ****************************************
  // pin synchronisation and edge finding
  // ****************************************
  pin_sync u_sync
  (
    .mclk(mclk),
    .rst(rst),
    .pin_in({mode_pin, serial_io_in, port_select_n, sclk}),
    .pin_sync_reg(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign sel_n_s = pins_s[1];
  assign sdi_s = pins_s[2];
  assign mode_s = pins_s[3];

  always @(posedge mclk)
  begin
    if (rst)
      sclk_d_reg <= 1'b0;
    else
      sclk_d_reg <= sclk_s;
  end

  // clock and data share sync delay, so data seen at the edge is aligned
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;

  // ****************************************
  // mode strap
  // ****************************************
  // caught each cycle while reset is held, frozen after release
  always @(posedge mclk)
  begin
    if (rst)
      full_duplex_mode <= mode_s;
  end

  // defaults during reset follow the live strap, later the captured one
  assign mode_full = rst ? mode_s : full_duplex_mode;
  assign lsb_first = ctrl0[`BIT_ORDER_POS];

  // ****************************************
  // register store
  // ****************************************
  reg_store u_regs
  (
    .mclk(mclk),
    .rst(rst),
    .mode_full(mode_full),
    .wr_en(wr_en_reg),
    .wr_addr(wr_addr_reg),
    .wr_data(wr_data_reg),
    .rd_addr(addr_reg),
    .rd_data(rd_data),
    .ctrl0(ctrl0),
    .iface(iface),
    .rxfilt(rxfilt),
    .interp(interp),
    .pllmul(pllmul),
    .ampgain(ampgain)
  );

  // ****************************************
  // serial state machine
  // ****************************************
  always @*
  begin
    shift_next = shift_in(shift_reg, sdi_s, lsb_first);
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= ST_INSTR;
      bit_cnt_reg <= `BIT_FIRST;
      shift_reg <= `DEF_OTHER;
      addr_reg <= `ADDR_ZERO;
      left_reg <= `LEFT_NONE;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= `ADDR_ZERO;
      wr_data_reg <= `DEF_OTHER;
      serial_io_out <= 1'b0;
      serial_io_oe <= 1'b0;
      soft_reset_pulse <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      wr_en_reg <= 1'b0;
      soft_reset_pulse <= 1'b0;
      if (sel_n_s)
      begin
        // deselected: count restarts and the line is released
        state_reg <= ST_INSTR;
        bit_cnt_reg <= `BIT_FIRST;
        serial_io_oe <= 1'b0;
        busy <= 1'b0;
      end
      else
      begin
        busy <= 1'b1;
        if (sclk_rise && state_reg != ST_DONE)
        begin
          shift_reg <= shift_next;
          bit_cnt_reg <= bit_cnt_reg + `CNT_ONE;
        end
        case (state_reg)
          ST_INSTR:
          begin
            if (sclk_rise && bit_cnt_reg == `BIT_LAST)
            begin
              left_reg <= shift_next[`INSTR_CNT_HI:`INSTR_CNT_LO];
              addr_reg <= shift_next[`INSTR_ADDR_HI:`INSTR_ADDR_LO];
              if (shift_next[`INSTR_RW_POS])
                state_reg <= ST_RDATA;
              else
                state_reg <= ST_WDATA;
            end
          end
          ST_WDATA:
          begin
            if (sclk_rise && bit_cnt_reg == `BIT_LAST)
            begin
              wr_en_reg <= 1'b1;
              wr_addr_reg <= addr_reg;
              wr_data_reg <= shift_next;
              if (addr_reg == `REG_CTRL0 && shift_next[`SOFT_RST_POS])
                soft_reset_pulse <= 1'b1;
              addr_reg <= next_addr(addr_reg, lsb_first);
              if (left_reg == `LEFT_NONE)
                state_reg <= ST_DONE;
              else
                left_reg <= left_reg - `LEFT_ONE;
            end
          end
          ST_RDATA:
          begin
            if (sclk_fall)
            begin
              // read data comes from the registered store output
              serial_io_oe <= 1'b1;
              serial_io_out <= pick_bit(rd_data, bit_cnt_reg, lsb_first);
            end
            if (sclk_rise && bit_cnt_reg == `BIT_LAST)
            begin
              addr_reg <= next_addr(addr_reg, lsb_first);
              if (left_reg == `LEFT_NONE)
              begin
                state_reg <= ST_DONE;
                serial_io_oe <= 1'b0;
              end
              else
                left_reg <= left_reg - `LEFT_ONE;
            end
          end
          default:
          begin
            // extra clocks after the last byte are ignored
            serial_io_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // configuration outputs
  // ****************************************
  always @(posedge mclk)
  begin
    if (rst)
    begin
      power_save_en <= 1'b0;
      bit_order_select <= 1'b0;
      rx_filter_cfg <= `DEF_OTHER;
      interp_cfg <= `DEF_OTHER;
      pll_mult_cfg <= `DEF_OTHER;
      amp_gain_cfg <= `DEF_OTHER;
    end
    else
    begin
      power_save_en <= iface[`PWR_SAVE_POS];
      bit_order_select <= ctrl0[`BIT_ORDER_POS];
      rx_filter_cfg <= rxfilt;
      interp_cfg <= interp;
      pll_mult_cfg <= pllmul;
      amp_gain_cfg <= ampgain;
    end
  end

endmodule // serial_register_port

/* File: src/serial_port_map.vh */
// Purpose: constants shared by the serial register port design files
// Assumes: 8-bit registers, 5-bit register addresses
// Notes: definitions only
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH

// ****************************************
// register space
// ****************************************
`define REG_COUNT 32
`define ADDR_W 5
`define DATA_W 8
`define ADDR_STEP 5'h01
`define ADDR_ZERO 5'h00

// ****************************************
// register addresses
// ****************************************
`define REG_CTRL0 5'h00
`define REG_IFACE 5'h01
`define REG_RXFILT 5'h02
`define REG_INTERP 5'h03
`define REG_PLLMUL 5'h04
`define REG_AMPGAIN 5'h05

// ****************************************
// field positions
// ****************************************
`define BIT_ORDER_POS 6
`define SOFT_RST_POS 5
`define SOFT_RST_MASK 8'h20
`define PWR_SAVE_POS 0
`define FULL_DUPLEX_POS 1
`define INSTR_RW_POS 7
`define INSTR_CNT_HI 6
`define INSTR_CNT_LO 5
`define INSTR_ADDR_HI 4
`define INSTR_ADDR_LO 0

// ****************************************
// reset values
// ****************************************
`define DEF_CTRL0 8'h00
`define DEF_IFACE_FD 8'h02
`define DEF_IFACE_HD 8'h01
`define DEF_RXFILT 8'h17
`define DEF_INTERP 8'h04
`define DEF_PLLMUL 8'h04
`define DEF_AMPGAIN 8'h24
`define DEF_OTHER 8'h00

// ****************************************
// serial framing
// ****************************************
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define BIT_MAX 3'h7
`define CNT_ONE 3'h1
`define LEFT_NONE 2'h0
`define LEFT_ONE 2'h1
`define SYNC_W 4
`define SYNC_IDLE 4'h2
`define SYNC_KEEP 4'h8

`endif

/* File: src/pin_sync.v */
// Purpose: two-stage synchroniser for pins entering the mclk domain
// Assumes: inputs are asynchronous levels
// Notes: only the second stage may be read by other logic
`timescale 1ns/1ps
`include "serial_port_map.vh"

module pin_sync
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // pins
  input wire [`SYNC_W-1:0] pin_in,
  // synchronised levels
  output reg [`SYNC_W-1:0] pin_sync_reg
);

  reg [`SYNC_W-1:0] meta_reg;

  // reset leaves select inactive so the port stays idle
  // strap bit keeps flowing in reset, else its level never reaches the capture
  always @(posedge mclk)
  begin
    if (rst)
    begin
      meta_reg <= (pin_in & `SYNC_KEEP) | `SYNC_IDLE;
      pin_sync_reg <= (meta_reg & `SYNC_KEEP) | `SYNC_IDLE;
    end
    else
    begin
      meta_reg <= pin_in;
      pin_sync_reg <= meta_reg;
    end
  end

endmodule // pin_sync

/* File: src/reg_store.v */
// Purpose: 32 x 8 configuration register store with registered read
// Assumes: one write per cycle, writes come from the serial port
// Notes: hard reset and soft reset load mode-dependent defaults
`timescale 1ns/1ps
`include "serial_port_map.vh"

module reg_store
(
  // clock and reset
  input wire mclk,
  input wire rst,
  input wire mode_full,
  // write port
  input wire wr_en,
  input wire [`ADDR_W-1:0] wr_addr,
  input wire [`DATA_W-1:0] wr_data,
  // read port
  input wire [`ADDR_W-1:0] rd_addr,
  output reg [`DATA_W-1:0] rd_data,
  // live register images
  output wire [`DATA_W-1:0] ctrl0,
  output wire [`DATA_W-1:0] iface,
  output wire [`DATA_W-1:0] rxfilt,
  output wire [`DATA_W-1:0] interp,
  output wire [`DATA_W-1:0] pllmul,
  output wire [`DATA_W-1:0] ampgain
);

  reg [`DATA_W-1:0] mem [0:`REG_COUNT-1];
  integer i;

  function [`DATA_W-1:0] default_of;
    input [`ADDR_W-1:0] a;
    input full;
    begin
      if (a == `REG_IFACE)
        default_of = full ? `DEF_IFACE_FD : `DEF_IFACE_HD;
      else if (a == `REG_RXFILT)
        default_of = `DEF_RXFILT;
      else if (a == `REG_INTERP)
        default_of = `DEF_INTERP;
      else if (a == `REG_PLLMUL)
        default_of = `DEF_PLLMUL;
      else if (a == `REG_AMPGAIN)
        default_of = `DEF_AMPGAIN;
      else if (a == `REG_CTRL0)
        default_of = `DEF_CTRL0;
      else
        default_of = `DEF_OTHER;
    end
  endfunction

  always @(posedge mclk)
  begin
    if (rst)
    begin
      for (i = 0; i < `REG_COUNT; i = i + 1)
        mem[i] <= default_of(i[`ADDR_W-1:0], mode_full);
    end
    else if (wr_en)
    begin
      if (wr_addr == `REG_CTRL0 && wr_data[`SOFT_RST_POS])
      begin
        // register 0 keeps the new value with the reset bit self-clearing
        for (i = 1; i < `REG_COUNT; i = i + 1)
          mem[i] <= default_of(i[`ADDR_W-1:0], mode_full);
        mem[0] <= wr_data & ~`SOFT_RST_MASK;
      end
      else
        mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge mclk)
  begin
    if (rst)
      rd_data <= `DEF_OTHER;
    else
      rd_data <= mem[rd_addr];
  end

  assign ctrl0 = mem[`REG_CTRL0];
  assign iface = mem[`REG_IFACE];
  assign rxfilt = mem[`REG_RXFILT];
  assign interp = mem[`REG_INTERP];
  assign pllmul = mem[`REG_PLLMUL];
  assign ampgain = mem[`REG_AMPGAIN];

endmodule // reg_store

/* File: tb/host_model.sv */
// Purpose: host controller driving the three-wire serial port
// Assumes: pins change at mclk edges, 64 ns serial clock period
// Notes: a released data line shows a pattern that toggles each cycle
`timescale 1ns/1ps

module host_model
(
  // clock
  input wire mclk,
  // device side of the data line
  input wire serial_io_out,
  input wire serial_io_oe,
  // host pins
  output reg sclk,
  output reg port_select_n,
  output wire serial_io_in
);
  reg host_oe;
  reg host_d;
  reg last_q;

  // ****************************************
  // line resolution
  // ****************************************
  // no pull on the line: a stale level must not pass for data
  assign serial_io_in = serial_io_oe ? serial_io_out : (host_oe ? host_d : ~last_q);

  initial
  begin
    sclk = 1'b0;
    port_select_n = 1'b1;
    host_oe = 1'b0;
    host_d = 1'b0;
    last_q = 1'b0;
  end

  always @(posedge mclk)
    last_q <= serial_io_in;

  // half of a 64 ns serial clock period
  task half;
    repeat (4) @(posedge mclk);
  endtask

  task xfer(input [7:0] ins, input [31:0] wd, input lsb, output [31:0] rd);
    integer i;
    integer j;
    integer nb;
    reg [39:0] fr;
    begin
      fr = {wd, ins};
      nb = 8 * (ins[6:5] + 2);
      rd = 32'h0;
      @(posedge mclk);
      port_select_n <= 1'b0;
      for (i = 0; i < nb; i = i + 1)
      begin
        j = lsb ? i % 8 : 7 - i % 8;
        half;
        sclk <= 1'b0;
        host_oe <= !(ins[7] && i > 7);
        host_d <= fr[i - i % 8 + j];
        half;
        sclk <= 1'b1;
        #1;
        if (i > 7)
          rd[8 * (i / 8 - 1) + j] = serial_io_in;
      end
      half;
      sclk <= 1'b0;
      host_oe <= 1'b0;
      half;
      port_select_n <= 1'b1;
      repeat (8) @(posedge mclk);
    end
  endtask

  // clock and data wiggle while not selected
  task noise;
    integer i;
    begin
      host_oe <= 1'b1;
      for (i = 0; i < 16; i = i + 1)
      begin
        half;
        sclk <= ~sclk;
        host_d <= i[1];
      end
      half;
      host_oe <= 1'b0;
    end
  endtask
endmodule // host_model

/* File: tb/port_checker.sv */
// Purpose: timing checks on the serial register port pins
// Assumes: one mclk domain, synchronous active-high reset
// Notes: attached by bind below
`timescale 1ns/1ps
`include "serial_port_map.vh"

module port_checker
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // pins
  input wire mode_pin,
  input wire sclk,
  input wire port_select_n,
  input wire serial_io_in,
  input wire serial_io_out,
  input wire serial_io_oe,
  // configuration and status
  input wire full_duplex_mode,
  input wire power_save_en,
  input wire bit_order_select,
  input wire [7:0] rx_filter_cfg,
  input wire [7:0] interp_cfg,
  input wire [7:0] pll_mult_cfg,
  input wire [7:0] amp_gain_cfg,
  input wire soft_reset_pulse,
  input wire busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_default_load: assert property ($fell(rst) |-> ##2
    (rx_filter_cfg == `DEF_RXFILT && interp_cfg == `DEF_INTERP && pll_mult_cfg == `DEF_PLLMUL
    && amp_gain_cfg == `DEF_AMPGAIN && power_save_en == !full_duplex_mode && !bit_order_select))
    else $error("defaults missing after reset");
  a_mode_frozen: assert property (!$past(rst) |-> $stable(full_duplex_mode))
    else $error("mode changed outside reset");
  a_busy_start: assert property ($fell(port_select_n) |-> ##[2:5] busy)
    else $error("port not busy after select");
  a_idle_quiet: assert property (port_select_n [*5] |-> !busy && !serial_io_oe)
    else $error("port active while deselected");
  a_cfg_hold: assert property ((port_select_n && !rst) [*8] |->
    $stable({rx_filter_cfg, interp_cfg, pll_mult_cfg, amp_gain_cfg, bit_order_select}))
    else $error("configuration changed while deselected");
  a_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  a_soft_defaults: assert property (soft_reset_pulse |-> ##[0:3]
    (amp_gain_cfg == `DEF_AMPGAIN && rx_filter_cfg == `DEF_RXFILT))
    else $error("soft reset left registers");
  a_out_on_fall: assert property (
    serial_io_oe && $past(serial_io_oe) && $changed(serial_io_out) |-> !$past(sclk, 2))
    else $error("read data changed near rising clock");
  a_oe_in_frame: assert property ($rose(serial_io_oe) |-> busy)
    else $error("data line driven outside a frame");

  c_soft: cover property (soft_reset_pulse);
  c_read: cover property ($rose(serial_io_oe));
  c_lsb: cover property ($rose(bit_order_select));
endmodule // port_checker

bind serial_register_port port_checker chk_u (.mclk, .rst, .mode_pin, .sclk, .port_select_n,
  .serial_io_in, .serial_io_out, .serial_io_oe, .full_duplex_mode, .power_save_en,
  .bit_order_select, .rx_filter_cfg, .interp_cfg, .pll_mult_cfg, .amp_gain_cfg,
  .soft_reset_pulse, .busy);

/* File: tb/tb_serial_register_port.sv */
// Purpose: self-checking bench for the serial register port
// Assumes: 125 MHz mclk, host model as the far side
// Notes: reset held four cycles so the mode strap passes its sync
`timescale 1ns/1ps

module tb_serial_register_port;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg mode_pin = 1'b0;
  reg pulse_seen = 1'b0;
  reg [31:0] rd;
  integer bad_count = 0;
  integer num_checks = 0;
  integer c;
  wire sclk, port_select_n, serial_io_in, serial_io_out, serial_io_oe;
  wire full_duplex_mode, power_save_en, bit_order_select, soft_reset_pulse, busy;
  wire [7:0] rx_filter_cfg, interp_cfg, pll_mult_cfg, amp_gain_cfg;
  wire [31:0] cfg = {rx_filter_cfg, interp_cfg, pll_mult_cfg, amp_gain_cfg};

  always #4 mclk = ~mclk;

  always @(posedge mclk)
    if (soft_reset_pulse === 1'b1)
      pulse_seen <= 1'b1;

  serial_register_port dut_u (.mclk, .rst, .mode_pin, .sclk, .port_select_n, .serial_io_in,
    .serial_io_out, .serial_io_oe, .full_duplex_mode, .power_save_en, .bit_order_select,
    .rx_filter_cfg, .interp_cfg, .pll_mult_cfg, .amp_gain_cfg, .soft_reset_pulse, .busy);

  host_model host_u (.mclk, .serial_io_out, .serial_io_oe, .sclk, .port_select_n, .serial_io_in);

  // ****************************************
  // checking and closing
  // ****************************************
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task hw_reset(input m);
    begin
      @(posedge mclk);
      rst <= 1'b1;
      mode_pin <= m;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(full_duplex_mode, m);
      chk(power_save_en, !m);
      chk(cfg, 32'h17040424);
      chk(bit_order_select, 1'b0);
      chk(busy, 1'b0);
    end
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    hw_reset(1'b0);
    hw_reset(1'b1);
    $display("done: defaults");
    host_u.xfer(8'h05, 32'hA5, 1'b0, rd);
    chk(amp_gain_cfg, 8'hA5);
    host_u.xfer(8'h85, 32'h0, 1'b0, rd);
    chk(rd, 32'hA5);
    host_u.xfer(8'h65, 32'h44332211, 1'b0, rd);
    chk(cfg, 32'h44332211);
    for (c = 0; c < 4; c = c + 1)
    begin
      host_u.xfer({1'b1, c[1:0], 5'h05}, 32'h0, 1'b0, rd);
      chk(rd, 32'h44332211 & ~(32'hFFFFFFFF << (8 * c + 8)));
    end
    $display("done: msb transfers");
    host_u.noise;
    chk(cfg, 32'h44332211);
    $display("done: deselected noise");
    // configuration change as a lone byte
    host_u.xfer(8'h00, 32'h40, 1'b0, rd);
    chk(bit_order_select, 1'b1);
    host_u.xfer(8'h22, 32'h6655, 1'b1, rd);
    chk(cfg[31:16], 16'h5566);
    host_u.xfer(8'hA2, 32'h0, 1'b1, rd);
    chk(rd, 32'h6655);
    $display("done: lsb transfers");
    host_u.xfer(8'h00, 32'h60, 1'b1, rd);
    chk(pulse_seen, 1'b1);
    chk(cfg, 32'h17040424);
    chk(bit_order_select, 1'b1);
    host_u.xfer(8'h80, 32'h0, 1'b1, rd);
    chk(rd, 32'h40);
    $display("done: soft reset");
    hw_reset(1'b0);
    $display("done: hard reset");
    end_of_test;
  end

  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    end_of_test;
  end
endmodule // tb_serial_register_port
